// [include/sbf_pkg.sv]
// Shared constants and carriers of the sensor batching queue.
// Assumes one clock domain and a plain register port from the host side.
`default_nettype none
package sbf_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] SBF_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SBF_ADDR_WTM = 8'h01;
  localparam logic [7:0] SBF_ADDR_HUB = 8'h02;
  localparam logic [7:0] SBF_ADDR_SLV0 = 8'h03;
  localparam logic [7:0] SBF_ADDR_STAT_LO = 8'h07;
  localparam logic [7:0] SBF_ADDR_STAT_HI = 8'h08;
  localparam logic [7:0] SBF_ADDR_OUT0 = 8'h10;
  localparam logic [7:0] SBF_ADDR_OUT6 = 8'h16;
  // ==========================================================
  // Field positions
  localparam int SBF_CTRL_STOP_BIT = 3;
  localparam int SBF_CTRL_INT_TRIG_BIT = 4;
  localparam int SBF_CTRL_ROUTE_FF_BIT = 5;
  localparam int SBF_CTRL_ROUTE_WU_BIT = 6;
  localparam int SBF_CTRL_ROUTE_6D_BIT = 7;
  localparam int SBF_SLV_BATCH_BIT = 3;
  localparam int SBF_STAT_WTM_BIT = 7;
  localparam int SBF_STAT_OVR_BIT = 6;
  localparam int SBF_STAT_FULL_BIT = 5;
  localparam int SBF_STAT_OVRL_BIT = 3;
  // ==========================================================
  // Sizes and reset values
  localparam int SBF_DEPTH = 512;
  localparam int SBF_AW = 9;
  localparam int SBF_WORD_BYTES = 7;
  localparam int SBF_EXT_SENS = 4;
  localparam int SBF_EXT_MAX_BYTES = 18;
  localparam logic [7:0] SBF_CTRL_RESET = 8'h00;
  localparam logic [8:0] SBF_WTM_RESET = 9'h000;
  localparam logic [7:0] SBF_SLV_RESET = 8'h00;
  localparam logic [7:0] SBF_TAG_NACK = 8'hC8;
  localparam logic [7:0] SBF_TAG_EXT0 = 8'h70;
  // ==========================================================
  // Mode codes
  localparam logic [2:0] SBF_MODE_BYPASS = 3'h0;
  localparam logic [2:0] SBF_MODE_FIFO = 3'h1;
  localparam logic [2:0] SBF_MODE_C2F = 3'h3;
  localparam logic [2:0] SBF_MODE_B2C = 3'h4;
  localparam logic [2:0] SBF_MODE_CONT = 3'h6;
  localparam logic [2:0] SBF_MODE_B2F = 3'h7;
  // Hub batch rate codes
  localparam logic [3:0] SBF_BDR_NONE = 4'h0;
  localparam logic [3:0] SBF_BDR_12HZ5 = 4'h1;
  localparam logic [3:0] SBF_BDR_104HZ = 4'h4;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] tag;
    logic [47:0] data;
  } sbf_word_type;
  typedef struct packed {
    logic valid;
    sbf_word_type word;
  } sbf_wreq_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sbf_bus_type;
endpackage
`default_nettype wire

// [core/sbf_hub_pack.sv]
// Builds external sensor words from the hub output bytes.
// Assumes a one-cycle hub_done pulse beside settled hub bytes and nack bits.
`default_nettype none
module sbf_hub_pack
  import sbf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hub_done,
  input wire logic [8*SBF_EXT_MAX_BYTES-1:0] hub_bytes,
  input wire logic [SBF_EXT_SENS*3-1:0] hub_len,
  input wire logic [SBF_EXT_SENS-1:0] hub_nack,
  input wire logic [SBF_EXT_SENS-1:0] batch_en,
  input wire logic ext_trigger,
  input wire logic word_taken,
  output sbf_wreq_type wreq
);
  import sbf_pkg::*;
  // ==========================================================
  // Snapshot and walk
  logic [8*SBF_EXT_MAX_BYTES-1:0] bytes_q;
  logic [SBF_EXT_SENS*3-1:0] len_q;
  logic [SBF_EXT_SENS-1:0] nack_q;
  logic [SBF_EXT_SENS-1:0] pend_q;
  logic [SBF_EXT_SENS-1:0] pend_d;
  logic [1:0] idx;
  logic [4:0] base [SBF_EXT_SENS];
  logic [47:0] field [SBF_EXT_SENS];
  wire any_pend = |pend_q;
  // Slave start offsets in hub order
  assign base[0] = 5'h00;
  genvar g;
  generate
    for (g = 0; g < SBF_EXT_SENS; g++) begin : g_slv
      logic [2:0] n;
      assign n = len_q[3*g +: 3];
      if (g > 0) begin : g_b
        assign base[g] = 5'(base[g-1] + len_q[3*(g-1) +: 3]);
      end
      for (genvar b = 0; b < 6; b++) begin : g_byte
        assign field[g][8*b +: 8] =
          (3'(b) < n && (5'(base[g] + 5'(b)) < 5'(SBF_EXT_MAX_BYTES)))
          ? bytes_q[8*(5'(base[g] + 5'(b))) +: 8] : 8'h00;
      end
    end
  endgenerate
  always_comb begin
    idx = 2'h0;
    for (int i = SBF_EXT_SENS - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        idx = 2'(i);
      end
    end
  end
  assign wreq.valid = any_pend;
  assign wreq.word.tag = nack_q[idx] ? SBF_TAG_NACK : 8'(SBF_TAG_EXT0 + 8'(idx));
  assign wreq.word.data = nack_q[idx] ? {46'h0, idx} : field[idx];
  always_comb begin
    pend_d = pend_q;
    if (any_pend && word_taken) begin
      pend_d[idx] = 1'b0;
    end
    if (hub_done && !any_pend && !ext_trigger) begin
      pend_d = batch_en;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_q <= '0;
      bytes_q <= '0;
      len_q <= '0;
      nack_q <= '0;
    end else begin
      pend_q <= pend_d;
      if (hub_done && !any_pend) begin
        bytes_q <= hub_bytes;
        len_q <= hub_len;
        nack_q <= hub_nack;
      end
    end
  end
endmodule
`default_nettype wire

// [core/sbf_core.sv]
// Sensor batching queue: storage, modes, status and host read port.
// Assumes same-clock sensor strobes and a trigger level from event logic.
//
// Our own choices: the strobed register port and the placing of the registers.
`default_nettype none
module sbf_core
  import sbf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire sbf_pkg::sbf_bus_type bus,
  output logic [7:0] rdata,
  input wire sbf_pkg::sbf_wreq_type main_wreq,
  input wire logic [3:0] fast_odr_code,
  input wire logic ext_trigger,
  input wire logic hub_done,
  input wire logic [8*sbf_pkg::SBF_EXT_MAX_BYTES-1:0] hub_bytes,
  input wire logic [sbf_pkg::SBF_EXT_SENS*3-1:0] hub_len,
  input wire logic [sbf_pkg::SBF_EXT_SENS-1:0] hub_nack,
  input wire logic ev_freefall,
  input wire logic ev_wakeup,
  input wire logic ev_orient,
  output logic [3:0] hub_batch_rate_code,
  output logic ext_slot
);
  import sbf_pkg::*;
  // ==========================================================
  // Control registers
  logic [7:0] ctrl_q;
  logic [8:0] wtm_q;
  logic [7:0] slave_cfg_q [SBF_EXT_SENS];
  wire [2:0] mode = ctrl_q[2:0];
  wire stop_at_watermark = ctrl_q[SBF_CTRL_STOP_BIT];
  wire internal_trig = ctrl_q[SBF_CTRL_INT_TRIG_BIT];
  logic [SBF_EXT_SENS-1:0] external_batch_enable;
  generate
    for (genvar s = 0; s < SBF_EXT_SENS; s++) begin : g_en
      assign external_batch_enable[s] = slave_cfg_q[s][SBF_SLV_BATCH_BIT];
    end
  endgenerate
  // ==========================================================
  // Hub rate code
  wire [1:0] hub_rate_select = slave_cfg_q[0][1:0];
  wire [3:0] rate_pick = 4'(SBF_BDR_12HZ5 + 4'(hub_rate_select));
  wire any_ext = |external_batch_enable;
  assign hub_batch_rate_code = (!any_ext || !internal_trig || ext_trigger) ? SBF_BDR_NONE :
    (rate_pick > fast_odr_code) ? fast_odr_code : rate_pick;
  // ==========================================================
  // Trigger edge detect
  logic trig_q;
  logic armed_q;
  logic armed_d;
  wire trig_now = (ev_freefall && ctrl_q[SBF_CTRL_ROUTE_FF_BIT]) ||
    (ev_wakeup && ctrl_q[SBF_CTRL_ROUTE_WU_BIT]) ||
    (ev_orient && ctrl_q[SBF_CTRL_ROUTE_6D_BIT]);
  wire trig_rise = trig_now && !trig_q;
  assign armed_d = (mode == SBF_MODE_BYPASS) ? 1'b0 : (armed_q || trig_rise);
  // ==========================================================
  // Effective behaviour
  typedef enum logic [2:0] {
    SBF_B_OFF = 3'b001,
    SBF_B_STOP = 3'b010,
    SBF_B_WRAP = 3'b100
  } sbf_beh_type;
  sbf_beh_type beh;
  always_comb begin
    unique case (mode)
      SBF_MODE_FIFO: beh = SBF_B_STOP;
      SBF_MODE_CONT: beh = SBF_B_WRAP;
      SBF_MODE_C2F: beh = armed_q ? SBF_B_STOP : SBF_B_WRAP;
      SBF_MODE_B2C: beh = armed_q ? SBF_B_WRAP : SBF_B_OFF;
      SBF_MODE_B2F: beh = armed_q ? SBF_B_STOP : SBF_B_OFF;
      default: beh = SBF_B_OFF;
    endcase
  end
  // ==========================================================
  // Storage
  sbf_word_type mem_q [SBF_DEPTH];
  logic [SBF_AW-1:0] wptr_q;
  logic [SBF_AW-1:0] rptr_q;
  logic [9:0] count_q;
  logic [9:0] count_d;
  logic [2:0] rbyte_q;
  sbf_word_type head_q;
  logic head_valid_q;
  logic ovr_q;
  logic ovr_latched_q;
  // Level limit with stop at watermark
  wire [9:0] limit = stop_at_watermark ? {1'b0, wtm_q} : 10'(SBF_DEPTH);
  wire at_limit = count_q >= limit;
  // Writer arbitration: main sensors first, then hub words
  sbf_wreq_type hub_wreq;
  wire hub_taken = hub_wreq.valid && !main_wreq.valid;
  wire wr_req = main_wreq.valid || hub_wreq.valid;
  sbf_word_type wr_word;
  assign wr_word = main_wreq.valid ? main_wreq.word : hub_wreq.word;
  assign ext_slot = hub_taken && wr_go && !ext_trigger;
  wire wr_stop = (beh == SBF_B_STOP) && at_limit;
  wire wr_go = wr_req && (beh != SBF_B_OFF) && !wr_stop;
  wire overwrite = wr_go && (beh == SBF_B_WRAP) && at_limit;
  // ==========================================================
  // Host read port
  wire sel_out = bus.addr >= SBF_ADDR_OUT0 && bus.addr <= SBF_ADDR_OUT6;
  wire rd_out = bus.rd && sel_out;
  wire pop = rd_out && rbyte_q == 3'(SBF_WORD_BYTES - 1) && count_q != 10'h000 && !overwrite;
  wire [6:0] [7:0] head_bytes = {head_q.data, head_q.tag};
  always_comb begin
    count_d = count_q;
    if (wr_go && !overwrite) begin
      count_d = 10'(count_d + 10'h001);
    end
    if (pop) begin
      count_d = 10'(count_d - 10'h001);
    end
  end
  // ==========================================================
  // Status flags
  // full one word below the level limit
  wire full_flag = (beh != SBF_B_OFF) && (count_q >= 10'(limit - 10'h001));
  wire watermark_flag = (count_q != 10'h000) && (count_q >= {1'b0, wtm_q});
  wire overrun_flag = ovr_q;
  wire [7:0] queue_status_low = count_q[7:0];
  wire [7:0] queue_status_high = {watermark_flag, overrun_flag, full_flag, 1'b0,
    ovr_latched_q, 1'b0, count_q[9:8]};
  // ==========================================================
  // Read mux
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    if (bus.addr == SBF_ADDR_CTRL) begin
      rmux = ctrl_q;
    end else if (bus.addr == SBF_ADDR_WTM) begin
      rmux = wtm_q[7:0];
    end else if (bus.addr == SBF_ADDR_HUB) begin
      rmux = {7'h00, wtm_q[8]};
    end else if (bus.addr >= SBF_ADDR_SLV0 &&
        bus.addr < 8'(SBF_ADDR_SLV0 + 8'(SBF_EXT_SENS))) begin
      rmux = slave_cfg_q[2'(bus.addr - SBF_ADDR_SLV0)];
    end else if (bus.addr == SBF_ADDR_STAT_LO) begin
      rmux = queue_status_low;
    end else if (bus.addr == SBF_ADDR_STAT_HI) begin
      rmux = queue_status_high;
    end else if (sel_out) begin
      rmux = head_valid_q ? head_bytes[rbyte_q] : 8'h00;
    end
  end
  // ==========================================================
  // Register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= SBF_CTRL_RESET;
      wtm_q <= SBF_WTM_RESET;
      for (int i = 0; i < SBF_EXT_SENS; i++) begin
        slave_cfg_q[i] <= SBF_SLV_RESET;
      end
    end else if (bus.wr) begin
      if (bus.addr == SBF_ADDR_CTRL) begin
        ctrl_q <= bus.wdata;
      end
      if (bus.addr == SBF_ADDR_WTM) begin
        wtm_q[7:0] <= bus.wdata;
      end
      if (bus.addr == SBF_ADDR_HUB) begin
        wtm_q[8] <= bus.wdata[0];
      end
      for (int i = 0; i < SBF_EXT_SENS; i++) begin
        if (bus.addr == 8'(SBF_ADDR_SLV0 + 8'(i))) begin
          slave_cfg_q[i] <= bus.wdata;
        end
      end
    end
  end
  // ==========================================================
  // Queue state
  always_ff @(posedge mclk) begin
    if (rst || beh == SBF_B_OFF) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      rbyte_q <= '0;
      ovr_q <= 1'b0;
      ovr_latched_q <= 1'b0;
      head_valid_q <= 1'b0;
    end else begin
      count_q <= count_d;
      if (wr_go) begin
        wptr_q <= SBF_AW'(wptr_q + 1'b1);
      end
      // Oldest slot moves with the overwrite
      if (overwrite || pop) begin
        rptr_q <= SBF_AW'(rptr_q + 1'b1);
      end
      if (rd_out) begin
        rbyte_q <= (rbyte_q == 3'(SBF_WORD_BYTES - 1)) ? 3'h0 : 3'(rbyte_q + 3'h1);
      end
      if (overwrite) begin
        ovr_q <= 1'b1;
        ovr_latched_q <= 1'b1;
      end else if (pop) begin
        ovr_q <= 1'b0;
      end
      if (bus.rd && bus.addr == SBF_ADDR_STAT_HI && !overwrite) begin
        ovr_latched_q <= 1'b0;
      end
      head_valid_q <= count_d != 10'h000;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_q <= 1'b0;
      armed_q <= 1'b0;
      rdata <= 8'h00;
      head_q <= '0;
    end else begin
      trig_q <= trig_now;
      armed_q <= armed_d;
      rdata <= bus.rd ? rmux : 8'h00;
      head_q <= mem_q[(overwrite || pop) ? SBF_AW'(rptr_q + 1'b1) : rptr_q];
    end
  end
  always_ff @(posedge mclk) begin
    if (wr_go) begin
      mem_q[wptr_q] <= wr_word;
    end
  end
  // ==========================================================
  // Hub word builder
  sbf_hub_pack u_hub (
    .mclk(mclk),
    .rst(rst),
    .hub_done(hub_done),
    .hub_bytes(hub_bytes),
    .hub_len(hub_len),
    .hub_nack(hub_nack),
    .batch_en(external_batch_enable),
    .ext_trigger(ext_trigger),
    .word_taken(hub_taken),
    .wreq(hub_wreq)
  );
endmodule
`default_nettype wire

// [tb/sbf_core_assertions.sv]
// Checker of the batching queue: read port, status reads, hub rate output.
// Assumes it is bound to sbf_core and sees only its ports.
`default_nettype none
module sbf_core_assertions
  import sbf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire sbf_pkg::sbf_bus_type bus,
  input wire logic [7:0] rdata,
  input wire logic [3:0] fast_odr_code,
  input wire logic ext_trigger,
  input wire logic [3:0] hub_batch_rate_code,
  input wire logic ext_slot
);
  // ========
  // Shadow of host writes
  logic [2:0] mode_q;
  logic [3:0] ext_en_q;
  wire ctrl_wr = bus.wr && bus.addr == SBF_ADDR_CTRL;
  wire slv_wr = bus.wr && bus.addr >= SBF_ADDR_SLV0 && bus.addr <= 8'h06;
  wire [1:0] slv_idx = bus.addr[1:0] - 2'h3;
  wire out_addr = bus.addr == SBF_ADDR_STAT_LO ||
    (bus.addr >= SBF_ADDR_OUT0 && bus.addr <= SBF_ADDR_OUT6);
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= SBF_MODE_BYPASS;
      ext_en_q <= 4'h0;
    end else if (ctrl_wr) begin
      mode_q <= bus.wdata[2:0];
    end else if (slv_wr) begin
      ext_en_q[slv_idx] <= bus.wdata[SBF_SLV_BATCH_BIT];
    end
  end
  // ========
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence stat_rd_s;
    bus.rd && bus.addr == SBF_ADDR_STAT_HI;
  endsequence
  sequence bypass_rd_s;
    mode_q == SBF_MODE_BYPASS ##0 bus.rd && out_addr;
  endsequence
  idle_read_zero_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside an answer cycle");
  reset_read_zero_a: assert property ($fell(rst) |-> rdata == 8'h00)
    else $error("read data not cleared by reset");
  bypass_empty_a: assert property (bypass_rd_s |=> rdata == 8'h00)
    else $error("bypass shows stored data");
  rate_off_a: assert property ((ext_trigger || ext_en_q == 4'h0) |->
    hub_batch_rate_code == SBF_BDR_NONE)
    else $error("hub rate code not zero");
  rate_range_a: assert property (hub_batch_rate_code <= SBF_BDR_104HZ)
    else $error("hub rate code out of range");
  rate_cap_a: assert property (hub_batch_rate_code != SBF_BDR_NONE |->
    hub_batch_rate_code <= fast_odr_code)
    else $error("hub rate above sensor rate");
  rate_stable_a: assert property (!$past(bus.wr) && $stable(fast_odr_code) &&
    $stable(ext_trigger) |-> $stable(hub_batch_rate_code))
    else $error("hub rate changed without cause");
  slot_gate_a: assert property (ext_slot |-> !ext_trigger && ext_en_q != 4'h0)
    else $error("time slot without batched hub slave");
  count_top_a: assert property (stat_rd_s ##1 rdata[1] |-> rdata[SBF_STAT_FULL_BIT] && !rdata[0])
    else $error("count bit 9 without full flag");
  overrun_full_a: assert property (stat_rd_s ##1 rdata[SBF_STAT_OVR_BIT] |-> rdata[SBF_STAT_FULL_BIT])
    else $error("overrun without full flag");
endmodule
bind sbf_core sbf_core_assertions u_chk (
  .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .fast_odr_code(fast_odr_code),
  .ext_trigger(ext_trigger), .hub_batch_rate_code(hub_batch_rate_code), .ext_slot(ext_slot)
);
`default_nettype wire

// [tb/sbf_host_model.sv]
// Host processor model: drives the register port and reads words back.
// Assumes a slave that answers a read in the next cycle and never stalls.
`default_nettype none
module sbf_host_model
  import sbf_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output sbf_pkg::sbf_bus_type bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_word(output sbf_word_type w);
    logic [7:0] b;
    rd(SBF_ADDR_OUT0, w.tag);
    for (int k = 0; k < 6; k++) begin
      rd(SBF_ADDR_OUT0 + 8'(k + 1), b);
      w.data[8*k +: 8] = b;
    end
  endtask
  // bypass first, then mode and routing
  task automatic set_mode(input logic [7:0] ctrl);
    wr(SBF_ADDR_CTRL, SBF_CTRL_RESET);
    wr(SBF_ADDR_CTRL, ctrl);
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Testbench of the batching queue: host model on the register port,
// bench-driven sensor words, hub results and event levels.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sbf_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  sbf_bus_type bus;
  logic [7:0] rdata;
  sbf_wreq_type main_wreq = '0;
  logic [3:0] fast_odr_code = SBF_BDR_104HZ;
  logic ext_trigger = 1'b0;
  logic hub_done = 1'b0;
  logic [8*SBF_EXT_MAX_BYTES-1:0] hub_bytes = '0;
  logic [SBF_EXT_SENS*3-1:0] hub_len = '0;
  logic [SBF_EXT_SENS-1:0] hub_nack = '0;
  logic [2:0] ev = 3'h0;
  logic [3:0] hub_batch_rate_code;
  logic ext_slot;
  int err_count = 0;
  int check_count = 0;
  logic [7:0] b;
  sbf_word_type w;
  sbf_core dut (
    .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .main_wreq(main_wreq),
    .fast_odr_code(fast_odr_code), .ext_trigger(ext_trigger), .hub_done(hub_done),
    .hub_bytes(hub_bytes), .hub_len(hub_len), .hub_nack(hub_nack), .ev_freefall(ev[0]),
    .ev_wakeup(ev[1]), .ev_orient(ev[2]), .hub_batch_rate_code(hub_batch_rate_code),
    .ext_slot(ext_slot)
  );
  sbf_host_model u_host (.mclk(mclk), .rdata(rdata), .bus(bus));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ========
  // Helpers
  task automatic test_done;
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_w(input sbf_word_type got, input sbf_word_type exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, b);
    chk_b(b, e);
  endtask
  task automatic push(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      main_wreq <= '{valid: 1'b1, word: '{tag: 8'h0A, data: 48'(base + i)}};
      @(posedge mclk);
      main_wreq.valid <= 1'b0;
    end
  endtask
  task automatic pulse_ev(input logic [2:0] v);
    @(posedge mclk);
    ev <= v;
    repeat (3) @(posedge mclk);
    ev <= 3'h0;
  endtask
  // ========
  // Scenarios
  task automatic sc_reset;
    expect_reg(SBF_ADDR_CTRL, SBF_CTRL_RESET);
    expect_reg(SBF_ADDR_STAT_LO, 8'h00);
    expect_reg(SBF_ADDR_STAT_HI, 8'h00);
    u_host.wr(8'h30, 8'hFF);
    expect_reg(8'h30, 8'h00);
  endtask
  task automatic sc_stop;
    u_host.wr(SBF_ADDR_WTM, 8'h04);
    u_host.set_mode({5'h01, SBF_MODE_FIFO});
    push(3, 0);
    expect_reg(SBF_ADDR_STAT_HI, 8'h20);
    push(1, 3);
    expect_reg(SBF_ADDR_STAT_HI, 8'hA0);
    push(2, 4);
    expect_reg(SBF_ADDR_STAT_LO, 8'h04);
    u_host.rd_word(w);
    chk_w(w, '{tag: 8'h0A, data: 48'h0});
    expect_reg(SBF_ADDR_STAT_LO, 8'h03);
    u_host.wr(SBF_ADDR_CTRL, SBF_CTRL_RESET);
    expect_reg(SBF_ADDR_STAT_LO, 8'h00);
    push(1, 0);
    expect_reg(SBF_ADDR_OUT0, 8'h00);
  endtask
  task automatic sc_cont;
    u_host.wr(SBF_ADDR_WTM, 8'h00);
    u_host.set_mode({5'h00, SBF_MODE_CONT});
    push(510, 0);
    expect_reg(SBF_ADDR_STAT_HI, 8'h81);
    push(1, 510);
    expect_reg(SBF_ADDR_STAT_HI, 8'hA1);
    push(1, 511);
    expect_reg(SBF_ADDR_STAT_HI, 8'hA2);
    push(1, 512);
    expect_reg(SBF_ADDR_STAT_HI, 8'hEA);
    expect_reg(SBF_ADDR_STAT_HI, 8'hE2);
    u_host.rd_word(w);
    chk_w(w, '{tag: 8'h0A, data: 48'h1});
    expect_reg(SBF_ADDR_STAT_HI, 8'hA1);
  endtask
  task automatic sc_c2f;
    u_host.wr(SBF_ADDR_WTM, 8'h04);
    u_host.set_mode({5'h05, SBF_MODE_C2F});
    push(6, 0);
    expect_reg(SBF_ADDR_STAT_LO, 8'h04);
    pulse_ev(3'h1);
    push(2, 6);
    u_host.rd_word(w);
    chk_w(w, '{tag: 8'h0A, data: 48'h2});
  endtask
  task automatic sc_b2x(input logic [2:0] mode, input int idx);
    u_host.set_mode({3'(1 << idx), 2'b00, mode});
    push(2, 0);
    pulse_ev(3'(7 & ~(1 << idx)));
    push(1, 0);
    expect_reg(SBF_ADDR_STAT_LO, 8'h00);
    pulse_ev(3'(1 << idx));
    push(3, 0);
    expect_reg(SBF_ADDR_STAT_LO, 8'h03);
  endtask
  task automatic sc_hub;
    int n;
    u_host.wr(SBF_ADDR_SLV0, 8'h08);
    u_host.wr(SBF_ADDR_SLV0 + 8'h01, 8'h08);
    u_host.set_mode({5'h02, SBF_MODE_FIFO});
    @(posedge mclk);
    hub_bytes <= 144'({8'h33, 8'hBB, 8'hAA});
    hub_len <= {3'd0, 3'd1, 3'd0, 3'd2};
    hub_nack <= 4'h2;
    hub_done <= 1'b1;
    @(posedge mclk);
    hub_done <= 1'b0;
    n = 0;
    b = 8'h00;
    while (b !== 8'h02 && n < 40) begin
      u_host.rd(SBF_ADDR_STAT_LO, b);
      n++;
    end
    if (b !== 8'h02) begin
      err_count++;
      $display("BAD %0t hub words missing", $time);
      test_done();
    end
    u_host.rd_word(w);
    chk_w(w, '{tag: SBF_TAG_EXT0, data: 48'hBBAA});
    u_host.rd_word(w);
    chk_w(w, '{tag: SBF_TAG_NACK, data: 48'h1});
    @(posedge mclk);
    ext_trigger <= 1'b1;
    @(posedge mclk);
    #1;
    chk_b({4'h0, hub_batch_rate_code}, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    sc_reset();
    sc_stop();
    sc_cont();
    sc_c2f();
    sc_b2x(SBF_MODE_B2F, 1);
    sc_b2x(SBF_MODE_B2C, 2);
    sc_hub();
    test_done();
  end
endmodule
`default_nettype wire
